//--- src/battery_query_consts.vh
// command codes, field positions and constants of the battery data query bank
`ifndef BATTERY_QUERY_CONSTS_VH
`define BATTERY_QUERY_CONSTS_VH

`define CMD_MODE_WORD      8'h03
`define CMD_HOST_RATE      8'h04
`define CMD_TIME_TO_FULL   8'h05
`define CMD_TIME_TO_EMPTY  8'h06
`define CMD_RATE_OK        8'h07
`define CMD_TEMPERATURE    8'h08
`define CMD_VOLTAGE        8'h09
`define CMD_CURRENT        8'h0a
`define CMD_AVG_CURRENT    8'h0b
`define CMD_ERROR_MARGIN   8'h0c
`define CMD_PCT_LEARNED    8'h0d
`define CMD_PCT_DESIGN     8'h0e
`define CMD_REMAINING      8'h0f

`define CAP_MODE_BIT       15
`define RATE_RESET         16'h0000
`define TIME_INVALID       16'hffff
`define TIME_MAX           16'hfffe
`define VOLT_MAX_MV        16'h4e20
`define PCT_MAX            7'h64
`define MARGIN_FULL_RESET  7'h64
`define MARGIN_LEARNED     7'h02
`define MARGIN_CLIPPED     7'h08
`define MARGIN_VOLT_CORR   7'h19
`define MARGIN_STEP        7'h01
`define CYCLES_PER_STEP    2'h3
`define MIN_PER_HOUR       16'h003c
`define PCT_SCALE          16'h0064
`define OK_WINDOW_FACTOR   16'h0168
`define REFRESH_PERIOD_MS  1000
`define CLK_MHZ            250
`define KHZ_PER_MHZ        1000
`define AVG_WARMUP_SEC     6'h3c
`define AVG_SHIFT          6
`define DIV_STEPS          6'h20

`endif

//--- src/battery_data_query_bank.v
// battery data words answered by command code, writable host rate and mode words, with rate predictions
`timescale 1ns/10ps
// Summary of operation
// - time-to-full at rate, invalid when rate not positive
// - rate write refreshes predictions within 5 ms
// - predictions recomputed from stored rate every second
// - time-to-empty at rate, invalid when rate not negative
// - rate-ok flag, always one unless discharging
// - temperature word in tenths of kelvin
// - voltage word in millivolts, up to 20000
// - signed instantaneous current in milliamps
// - minute average current, instant during first minute
// - error margin loads 100 percent at reset
// - unclipped learning cycle sets margin to 2
// - clipped learning sets 8, unless already below
// - margin plus one per four cycle counts
// - voltage correction sets margin to 25
// - percent of learned capacity, limited 0 to 100
// - percent of design capacity, may exceed 100
// - remaining capacity in mAh or 10 mWh
// - mode bit 15 selects current or power units
// - signed host rate value, resets to zero
`include "battery_query_consts.vh"

module battery_data_query_bank #(
  parameter SEC_CYCLES = `REFRESH_PERIOD_MS * `CLK_MHZ * `KHZ_PER_MHZ
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  cmdCode,
  input  wire        readStrobe,
  input  wire        writeStrobe,
  input  wire [15:0] writeData,
  input  wire [15:0] tempTenthK,
  input  wire [15:0] voltMv,
  input  wire [15:0] currentMa,
  input  wire [15:0] remainMah,
  input  wire [15:0] remain10mWh,
  input  wire [15:0] fullMah,
  input  wire [15:0] full10mWh,
  input  wire [15:0] designMah,
  input  wire [15:0] design10mWh,
  input  wire        learnDone,
  input  wire        learnClipped,
  input  wire        cycleCountInc,
  input  wire        voltCorrection,
  output reg  [15:0] readData_ff,
  output reg         readAck_ff,
  output reg         cmdError_ff
);

  // ****************************************
  // sequencer states
  // ****************************************
  localparam ST_IDLE  = 4'b0001;
  localparam ST_LOAD  = 4'b0010;
  localparam ST_DIV   = 4'b0100;
  localparam ST_STORE = 4'b1000;
  localparam JOB_TTF  = 2'h0;
  localparam JOB_TTE  = 2'h1;
  localparam JOB_REL  = 2'h2;
  localparam JOB_ABS  = 2'h3;

  reg signed [15:0] rateFf;
  reg               capModeFf;
  reg        [15:0] ttfFf;
  reg        [15:0] tteFf;
  reg               rateOkFf;
  reg        [15:0] relFf;
  reg        [15:0] absFf;
  reg        [6:0]  marginFf;
  reg        [1:0]  cycCntFf;
  reg signed [21:0] accFf;
  reg        [5:0]  secFf;
  reg        [27:0] tickCntFf;
  reg               pendFf;
  reg        [3:0]  stateFf;
  reg        [1:0]  jobFf;
  reg        [5:0]  stepFf;
  reg        [31:0] quoFf;
  reg        [16:0] remFf;
  reg        [15:0] divisorFf;
  reg               skipFf;

  // ****************************************
  // unit selection and operands
  // ****************************************
  wire [15:0] remSel    = capModeFf ? remain10mWh : remainMah;
  wire [15:0] fullSel   = capModeFf ? full10mWh : fullMah;
  wire [15:0] designSel = capModeFf ? design10mWh : designMah;
  wire        rateNeg   = rateFf[15];
  wire        rateZero  = (rateFf == `RATE_RESET);
  wire [15:0] rateMag   = rateNeg ? (~rateFf + 16'h0001) : rateFf;
  wire [15:0] toFull    = (fullSel > remSel) ? (fullSel - remSel) : 16'h0000;
  wire [31:0] tickWide  = {4'h0, tickCntFf};
  wire        secTick   = (tickWide == SEC_CYCLES - 1);
  wire [15:0] voltClamp = (voltMv > `VOLT_MAX_MV) ? `VOLT_MAX_MV : voltMv;
  wire        writeRate = writeStrobe && (cmdCode == `CMD_HOST_RATE);
  wire        startRun  = stateFf[0] && pendFf;

  reg [31:0] opDividend;
  reg [15:0] opDivisor;
  reg        opSkip;

  always @* begin
    opDividend = 32'h00000000;
    opDivisor  = 16'h0000;
    opSkip     = 1'b0;
    case (jobFf)
      JOB_TTF: begin
        opDividend = toFull * `MIN_PER_HOUR;
        opDivisor  = rateMag;
        opSkip     = rateNeg || rateZero;
      end
      JOB_TTE: begin
        opDividend = remSel * `MIN_PER_HOUR;
        opDivisor  = rateMag;
        opSkip     = !rateNeg;
      end
      JOB_REL: begin
        opDividend = remSel * `PCT_SCALE;
        opDivisor  = fullSel;
      end
      default: begin
        opDividend = remSel * `PCT_SCALE;
        opDivisor  = designSel;
      end
    endcase
  end

  // ****************************************
  // restoring divider step
  // ****************************************
  wire [16:0] trialRem = {remFf[15:0], quoFf[31]};
  wire        trialGe  = (trialRem >= {1'b0, divisorFf});
  wire [16:0] nextRem  = trialGe ? (trialRem - {1'b0, divisorFf}) : trialRem;

  wire        divZero  = (divisorFf == 16'h0000);
  wire        quoBig   = (quoFf[31:16] != 16'h0000);
  wire [15:0] timeRes  = (skipFf || divZero) ? `TIME_INVALID :
                         (quoBig || quoFf[15:0] > `TIME_MAX) ? `TIME_MAX : quoFf[15:0];
  wire [15:0] relRes   = divZero ? 16'h0000 :
                         (quoBig || quoFf[15:0] > {9'h000, `PCT_MAX}) ?
                         {9'h000, `PCT_MAX} : quoFf[15:0];
  wire [15:0] absRes   = divZero ? 16'h0000 : (quoBig ? 16'hffff : quoFf[15:0]);

  // ****************************************
  // host writes and refresh request
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rateFf    <= `RATE_RESET;
      capModeFf <= 1'b0;
      pendFf    <= 1'b0;
    end else begin
      if (writeRate) begin
        rateFf <= writeData;
      end
      if (writeStrobe && cmdCode == `CMD_MODE_WORD) begin
        capModeFf <= writeData[`CAP_MODE_BIT];
      end
      // a new request landing as a run starts is kept for the next run
      pendFf <= writeRate || secTick || (pendFf && !startRun);
    end
  end

  // ****************************************
  // one-second time base
  // ****************************************
  // free running, a rate write never restarts it, so the period stays fixed
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickCntFf <= 28'h0000000;
    end else if (secTick) begin
      tickCntFf <= 28'h0000000;
    end else begin
      tickCntFf <= tickCntFf + 28'h0000001;
    end
  end

  // ****************************************
  // prediction sequencer
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf   <= ST_IDLE;
      jobFf     <= JOB_TTF;
      stepFf    <= 6'h00;
      quoFf     <= 32'h00000000;
      remFf     <= 17'h00000;
      divisorFf <= 16'h0000;
      skipFf    <= 1'b0;
      ttfFf     <= `TIME_INVALID;
      tteFf     <= `TIME_INVALID;
      rateOkFf  <= 1'b1;
      relFf     <= 16'h0000;
      absFf     <= 16'h0000;
    end else begin
      case (stateFf)
        ST_IDLE: begin
          if (pendFf) begin
            stateFf <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          quoFf     <= opDividend;
          remFf     <= 17'h00000;
          divisorFf <= opDivisor;
          skipFf    <= opSkip;
          stepFf    <= 6'h00;
          if (jobFf == JOB_TTE) begin
            // extra load for ten seconds: capacity per hour over 360
            rateOkFf <= !rateNeg || ({16'h0000, remSel} * `OK_WINDOW_FACTOR >=
                        {16'h0000, rateMag});
          end
          stateFf <= ST_DIV;
        end
        ST_DIV: begin
          quoFf  <= {quoFf[30:0], trialGe};
          remFf  <= nextRem;
          stepFf <= stepFf + 6'h01;
          if (stepFf == `DIV_STEPS - 6'h01) begin
            stateFf <= ST_STORE;
          end
        end
        ST_STORE: begin
          // whole-word update, a read never sees half a result
          case (jobFf)
            JOB_TTF: ttfFf <= timeRes;
            JOB_TTE: tteFf <= timeRes;
            JOB_REL: relFf <= relRes;
            default: absFf <= absRes;
          endcase
          if (jobFf == JOB_ABS) begin
            jobFf   <= JOB_TTF;
            stateFf <= ST_IDLE;
          end else begin
            jobFf   <= jobFf + 2'h1;
            stateFf <= ST_LOAD;
          end
        end
        default: begin
          stateFf <= ST_IDLE;
          jobFf   <= JOB_TTF;
        end
      endcase
    end
  end

  // ****************************************
  // averaged current
  // ****************************************
  wire signed [21:0] curWide = {{6{currentMa[15]}}, currentMa};
  wire signed [21:0] curAcc  = curWide <<< `AVG_SHIFT;
  wire signed [21:0] accStep = accFf + curWide - (accFf >>> `AVG_SHIFT);
  wire        [15:0] avgWord = (secFf < `AVG_WARMUP_SEC) ? currentMa :
                               accFf[15 + `AVG_SHIFT:`AVG_SHIFT];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accFf <= 22'h000000;
      secFf <= 6'h00;
    end else if (secTick) begin
      // first-order filter, time constant near one minute of ticks
      if (secFf < `AVG_WARMUP_SEC) begin
        accFf <= curAcc;
        secFf <= secFf + 6'h01;
      end else begin
        accFf <= accStep;
      end
    end
  end

  // ****************************************
  // state-of-charge error margin
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      marginFf <= `MARGIN_FULL_RESET;
      cycCntFf <= 2'h0;
    end else begin
      if (voltCorrection) begin
        marginFf <= `MARGIN_VOLT_CORR;
      end else if (learnDone && !learnClipped) begin
        marginFf <= `MARGIN_LEARNED;
      end else if (learnDone && learnClipped) begin
        if (marginFf >= `MARGIN_CLIPPED) begin
          marginFf <= `MARGIN_CLIPPED;
        end
      end else if (cycleCountInc && cycCntFf == `CYCLES_PER_STEP) begin
        if (marginFf < `PCT_MAX) begin
          marginFf <= marginFf + `MARGIN_STEP;
        end
      end
      if (learnDone) begin
        cycCntFf <= 2'h0;
      end else if (cycleCountInc) begin
        cycCntFf <= cycCntFf + 2'h1;
      end
    end
  end

  // ****************************************
  // read-word answer
  // ****************************************
  reg [15:0] readMux;
  reg        readBad;

  always @* begin
    readMux = 16'h0000;
    readBad = 1'b0;
    case (cmdCode)
      `CMD_MODE_WORD:     readMux = {capModeFf, 15'h0000};
      `CMD_HOST_RATE:     readMux = rateFf;
      `CMD_TIME_TO_FULL:  readMux = ttfFf;
      `CMD_TIME_TO_EMPTY: readMux = tteFf;
      `CMD_RATE_OK:       readMux = {15'h0000, rateOkFf};
      `CMD_TEMPERATURE:   readMux = tempTenthK;
      `CMD_VOLTAGE:       readMux = voltClamp;
      `CMD_CURRENT:       readMux = currentMa;
      `CMD_AVG_CURRENT:   readMux = avgWord;
      `CMD_ERROR_MARGIN:  readMux = {9'h000, marginFf};
      `CMD_PCT_LEARNED:   readMux = relFf;
      `CMD_PCT_DESIGN:    readMux = absFf;
      `CMD_REMAINING:     readMux = remSel;
      default:            readBad = 1'b1;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readData_ff <= 16'h0000;
      readAck_ff  <= 1'b0;
      cmdError_ff <= 1'b0;
    end else begin
      readAck_ff  <= readStrobe;
      cmdError_ff <= readStrobe && readBad;
      if (readStrobe) begin
        readData_ff <= readMux;
      end
    end
  end

endmodule

//--- testbench/battery_query_asserts.sv
// port checker for the battery data query bank
`timescale 1ns/10ps
`include "battery_query_consts.vh"
module battery_query_checker (
  input wire        mclk,
  input wire        rst_n,
  input wire [7:0]  cmdCode,
  input wire        readStrobe,
  input wire [15:0] tempTenthK,
  input wire [15:0] voltMv,
  input wire [15:0] currentMa,
  input wire [15:0] readData_ff,
  input wire        readAck_ff,
  input wire        cmdError_ff
);
  // ********
  // read port
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd  = readStrobe;
  wire bad = cmdCode < 8'h03 || cmdCode > 8'h0f;
  a_ack_after_read: assert property (rd |=> readAck_ff) else $error("no ack");
  a_no_stray_ack: assert property (!rd |=> !readAck_ff && !cmdError_ff) else $error("stray ack");
  a_unmapped_err: assert property (rd && bad |=> cmdError_ff && readData_ff == 16'h0000)
    else $error("unmapped read");
  a_mapped_ok: assert property (rd && !bad |=> !cmdError_ff) else $error("mapped read refused");
  a_word_holds: assert property (!rd |=> $stable(readData_ff)) else $error("word moved");
  a_temp_live: assert property (rd && cmdCode == `CMD_TEMPERATURE |=>
    readData_ff == $past(tempTenthK)) else $error("temperature word");
  a_volt_clamp: assert property (rd && cmdCode == `CMD_VOLTAGE |=> readData_ff ==
    ($past(voltMv) > `VOLT_MAX_MV ? `VOLT_MAX_MV : $past(voltMv))) else $error("voltage word");
  a_current_live: assert property (rd && cmdCode == `CMD_CURRENT |=>
    readData_ff == $past(currentMa)) else $error("current word");
  a_margin_range: assert property (rd && cmdCode == `CMD_ERROR_MARGIN |=>
    readData_ff >= 16'h0002 && readData_ff <= 16'h0064) else $error("margin range");
  a_rel_limit: assert property (rd && cmdCode == `CMD_PCT_LEARNED |=>
    readData_ff <= 16'h0064) else $error("relative charge range");
  a_ok_boolean: assert property (rd && cmdCode == `CMD_RATE_OK |=>
    readData_ff <= 16'h0001) else $error("rate flag not boolean");
  c_bad_read: cover property (rd && bad);
  c_margin_read: cover property (rd && cmdCode == `CMD_ERROR_MARGIN);
  c_back_to_back: cover property (rd ##1 rd);
endmodule
bind battery_data_query_bank battery_query_checker chk (.mclk(mclk), .rst_n(rst_n),
  .cmdCode(cmdCode), .readStrobe(readStrobe), .tempTenthK(tempTenthK), .voltMv(voltMv),
  .currentMa(currentMa), .readData_ff(readData_ff), .readAck_ff(readAck_ff),
  .cmdError_ff(cmdError_ff));

//--- testbench/host_model.sv
// host stand-in issuing read-word and write-word requests
`timescale 1ns/10ps
module host_model (
  input  wire        mclk,
  output reg  [7:0]  cmdCode,
  output reg         readStrobe,
  output reg         writeStrobe,
  output reg  [15:0] writeData,
  input  wire [15:0] readData_ff,
  input  wire        readAck_ff,
  input  wire        cmdError_ff
);
  // ********
  // requests
  // ********
  initial begin
    cmdCode = 8'h00;
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    writeData = 16'h0000;
  end
  // released lines show the inverse, never a stale value
  task rd(input [7:0] c, output [15:0] d, output e);
    begin
      @(posedge mclk);
      cmdCode <= c;
      readStrobe <= 1'b1;
      @(posedge mclk);
      readStrobe <= 1'b0;
      cmdCode <= ~c;
      #1;
      d = (readAck_ff === 1'b1) ? readData_ff : 16'hxxxx;
      e = cmdError_ff;
    end
  endtask
  // rate is a signed word, mode word carries the unit bit
  task wr(input [7:0] c, input [15:0] w);
    begin
      @(posedge mclk);
      cmdCode <= c;
      writeData <= w;
      writeStrobe <= 1'b1;
      @(posedge mclk);
      writeStrobe <= 1'b0;
      cmdCode <= ~c;
      writeData <= ~w;
    end
  endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the battery data query bank
`timescale 1ns/10ps
`include "battery_query_consts.vh"
module tb_top;
  // ********
  // bench
  // ********
  reg         mclk;
  reg         rst_n;
  reg  [15:0] m [0:8];
  reg  [2:0]  ev;
  reg         clip;
  reg  [15:0] d;
  reg         e;
  wire [7:0]  cmdCode;
  wire        rdS;
  wire        wrS;
  wire [15:0] wd;
  wire [15:0] rdata;
  wire        ack;
  wire        err;
  integer     num_errors;
  integer     compares;
  integer     cyc;
  host_model host (.mclk(mclk), .cmdCode(cmdCode), .readStrobe(rdS), .writeStrobe(wrS),
    .writeData(wd), .readData_ff(rdata), .readAck_ff(ack), .cmdError_ff(err));
  // short second keeps the periodic refresh inside the run
  battery_data_query_bank #(.SEC_CYCLES(200)) DUT (.mclk(mclk), .rst_n(rst_n),
    .cmdCode(cmdCode), .readStrobe(rdS), .writeStrobe(wrS), .writeData(wd),
    .tempTenthK(m[0]), .voltMv(m[1]), .currentMa(m[2]), .remainMah(m[3]),
    .remain10mWh(m[4]), .fullMah(m[5]), .full10mWh(m[6]), .designMah(m[7]),
    .design10mWh(m[8]), .learnDone(ev[1]), .learnClipped(clip), .cycleCountInc(ev[0]),
    .voltCorrection(ev[2]), .readData_ff(rdata), .readAck_ff(ack), .cmdError_ff(err));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] c, input [15:0] x);
    begin
      host.rd(c, d, e);
      chk(d, x);
      chk({15'h0000, e}, {15'h0000, c < 8'h03 || c > 8'h0f});
    end
  endtask
  task pulse(input [2:0] v, input cl);
    begin
      @(posedge mclk);
      ev <= v;
      clip <= cl;
      @(posedge mclk);
      ev <= 3'h0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ev = 3'h0;
    clip = 1'b0;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    m[0] = 16'h0b9a;
    m[1] = 16'h61a8;
    m[2] = 16'hfc18;
    m[3] = 16'h01f4;
    m[4] = 16'h00c8;
    m[5] = 16'h03e8;
    m[6] = 16'h0190;
    m[7] = 16'h0190;
    m[8] = 16'h0320;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rc(`CMD_ERROR_MARGIN, 16'h0064);
    rc(`CMD_HOST_RATE, 16'h0000);
    rc(`CMD_TIME_TO_FULL, 16'hffff);
    rc(`CMD_TIME_TO_EMPTY, 16'hffff);
    rc(`CMD_RATE_OK, 16'h0001);
    rc(`CMD_MODE_WORD, 16'h0000);
    rc(`CMD_TEMPERATURE, 16'h0b9a);
    rc(`CMD_VOLTAGE, 16'h4e20);
    rc(`CMD_CURRENT, 16'hfc18);
    rc(`CMD_AVG_CURRENT, 16'hfc18);
    rc(`CMD_REMAINING, 16'h01f4);
    rc(8'h10, 16'h0000);
    rc(8'h00, 16'h0000);
    host.wr(`CMD_HOST_RATE, 16'h0064);
    repeat (300) @(posedge mclk);
    rc(`CMD_TIME_TO_FULL, 16'h012c);
    rc(`CMD_TIME_TO_EMPTY, 16'hffff);
    rc(`CMD_PCT_LEARNED, 16'h0032);
    rc(`CMD_PCT_DESIGN, 16'h007d);
    host.wr(`CMD_HOST_RATE, 16'hff9c);
    host.wr(`CMD_TIME_TO_FULL, 16'h1234);
    repeat (300) @(posedge mclk);
    rc(`CMD_TIME_TO_EMPTY, 16'h012c);
    rc(`CMD_TIME_TO_FULL, 16'hffff);
    rc(`CMD_RATE_OK, 16'h0001);
    @(posedge mclk);
    m[3] <= 16'h0032;
    host.wr(`CMD_HOST_RATE, 16'h8000);
    repeat (300) @(posedge mclk);
    rc(`CMD_RATE_OK, 16'h0000);
    rc(`CMD_TIME_TO_EMPTY, 16'h0000);
    @(posedge mclk);
    m[3] <= 16'h04b0;
    repeat (500) @(posedge mclk);
    rc(`CMD_TIME_TO_EMPTY, 16'h0002);
    rc(`CMD_PCT_LEARNED, 16'h0064);
    rc(`CMD_PCT_DESIGN, 16'h012c);
    host.wr(`CMD_MODE_WORD, 16'h8000);
    rc(`CMD_MODE_WORD, 16'h8000);
    rc(`CMD_REMAINING, 16'h00c8);
    repeat (500) @(posedge mclk);
    rc(`CMD_PCT_LEARNED, 16'h0032);
    rc(`CMD_PCT_DESIGN, 16'h0019);
    pulse(3'h4, 1'b0);
    rc(`CMD_ERROR_MARGIN, 16'h0019);
    pulse(3'h2, 1'b0);
    rc(`CMD_ERROR_MARGIN, 16'h0002);
    repeat (4) pulse(3'h1, 1'b0);
    rc(`CMD_ERROR_MARGIN, 16'h0003);
    pulse(3'h2, 1'b1);
    rc(`CMD_ERROR_MARGIN, 16'h0003);
    pulse(3'h4, 1'b0);
    pulse(3'h2, 1'b1);
    rc(`CMD_ERROR_MARGIN, 16'h0008);
    // past the first minute of ticks the filter path answers
    repeat (10400) @(posedge mclk);
    rc(`CMD_AVG_CURRENT, 16'hfc18);
    @(posedge mclk);
    m[2] <= 16'h03e8;
    // 200 edges hold exactly one tick: one filter step toward the new current
    repeat (199) @(posedge mclk);
    rc(`CMD_AVG_CURRENT, 16'hfc37);
    rc(`CMD_CURRENT, 16'h03e8);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rc(`CMD_ERROR_MARGIN, 16'h0064);
    rc(`CMD_HOST_RATE, 16'h0000);
    rc(`CMD_TIME_TO_EMPTY, 16'hffff);
    finish_test;
  end
endmodule
